/* rtl/ssi_encoder_channel.sv */
// Decided for this implementation: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
// Contract
// RULE1: idle clock and data lines rest high
// RULE2: encoder latches position on first falling edge
// RULE3: encoder shifts MSB first on rising edges
// RULE4: optional zero bit then optional parity bit
// RULE5: no new burst before recovery time ends
// RULE6: select 01 and listen 0 gives master
// RULE7: listen-select bit sits at control bit 14
// RULE8: master uses count, code, zero, parity, rate
// RULE9: data write starts burst; finish updates status
// RULE10: multi-channel trigger starts enabled master channel
// RULE11: read-error reads zero in master mode
// RULE12: select 01 and listen 1 gives listener
// RULE13: listener ignores rate, measures link clock
// RULE14: listener busy while waiting, clear at word end
// RULE15: data read in listen re-arms, busy set
// RULE16: data writes ignored in listen mode
// RULE17: watchdog four times first pulse, error on expiry
// RULE18: break setting stops or continues after error
// RULE19: capture joined mid-transfer flags read error
// RULE20: select 00/11 off, 01 serial, 10 counter (here 10 is also off, there is no counter mode)
// RULE21: data-valid interrupt when transfer ends, if enabled
// RULE22: master samples on falling edge, MSB first
// RULE23: parity mismatch flags parity error
module ssi_encoder_channel
#(
  parameter int DATA_W       = 32,
  parameter int RECOVERY_CYC = ssi_pkg::RECOVERY_CYC
) (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // wishbone slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [ssi_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  // multi-channel read trigger
  input  wire logic                    mcr_trigger_i,
  // serial link
  output logic                         ssi_clk_o,
  input  wire logic                    ssi_clk_in_i,
  input  wire logic                    ssi_data_i,
  // event
  output logic                         data_valid_irq_o
);
  import ssi_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  chan_state_t          state;
  chan_state_t          next_state;
  logic [31:0]          ctrl;
  logic [31:0]          next_ctrl;
  logic [TIMER_W-1:0]   timer;
  logic [TIMER_W-1:0]   next_timer;
  logic [CNT_W-1:0]     bitcnt;
  logic [CNT_W-1:0]     next_bitcnt;
  logic [DATA_W-1:0]    shift;
  logic [DATA_W-1:0]    next_shift;
  logic [DATA_W-1:0]    result;
  logic [DATA_W-1:0]    next_result;
  logic [WIDTH_W-1:0]   width;
  logic [WIDTH_W-1:0]   next_width;
  logic [31:0]          next_rdata;
  logic                 par_acc, next_par_acc, par_bit, next_par_bit;
  logic                 pend, next_pend, taint, next_taint;
  logic                 busy, next_busy, rderr, next_rderr;
  logic                 parerr, next_parerr, valid, next_valid;
  logic                 next_clk, next_irq, next_ack;
  logic                 finish, sample, sbit, bad;
  logic                 lk, lk_d, dt;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic                 take, wr, rd, ctrl_wr, data_wr, data_rd, stat_wr;
  logic                 ssi_mode, listen, brk, start, fall, rise;
  logic [CNT_W-1:0]     bc_raw, bc_eff, total;
  logic [CTRL_CR_W-1:0] cr;
  logic [TIMER_W-1:0]   half_cyc, rec_cyc, reload;

  assign take     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr       = take & wb_we_i;
  assign rd       = take & ~wb_we_i;
  assign ctrl_wr  = wr & (wb_adr_i == REG_CTRL);
  assign data_wr  = wr & (wb_adr_i == REG_DATA);
  assign stat_wr  = wr & (wb_adr_i == REG_STATUS) & wb_sel_i[0];
  assign data_rd  = rd & (wb_adr_i == REG_DATA);
  assign ssi_mode = (ctrl[CTRL_IFSEL_LSB+:2] == IFSEL_SSI); // RULE20
  assign listen   = ctrl[CTRL_LISTEN]; // RULE7
  assign brk      = ctrl[CTRL_BREAK];
  assign bc_raw   = ctrl[CTRL_BC_LSB+:CNT_W];
  // word length limited to 1..DATA_W
  assign bc_eff   = (bc_raw == '0) ? CNT_W'(1) :
                    (bc_raw > CNT_W'(DATA_W)) ? CNT_W'(DATA_W) : bc_raw;
  assign total    = bc_eff + CNT_W'(ctrl[CTRL_ZB]) + CNT_W'(ctrl[CTRL_PAR]); // RULE4
  assign cr       = ctrl[CTRL_CR_LSB+:CTRL_CR_W];
  // a zero rate field runs at the fastest rate rather than stalling
  assign half_cyc = TIMER_W'(((cr == '0) ? 1 : int'(cr)) * HALF_US_CYC) - TIMER_W'(1); // RULE8
  assign rec_cyc  = TIMER_W'(RECOVERY_CYC);
  assign reload   = TIMER_W'(width) << WD_SHIFT; // RULE17
  assign start    = data_wr | (mcr_trigger_i & ctrl[CTRL_MCR_EN]); // RULE9 RULE10
  assign fall     = lk_d & ~lk;
  assign rise     = ~lk_d & lk;

  function automatic logic [DATA_W-1:0] gray2bin(input logic [DATA_W-1:0] g);
    logic [DATA_W-1:0] b;
    b[DATA_W-1] = g[DATA_W-1];
    for (int i = DATA_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  ssi_sync #(.IDLE(LINE_IDLE)) u_sync_clk (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .din_i  (ssi_clk_in_i),
    .dout_o (lk)
  );

  ssi_sync #(.IDLE(LINE_IDLE)) u_sync_dat (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .din_i  (ssi_data_i),
    .dout_o (dt)
  );

  // ----------------------------------------------------------------
  // channel sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;   next_timer = timer;     next_bitcnt = bitcnt;
    next_shift = shift;   next_par_acc = par_acc; next_par_bit = par_bit;
    next_clk = ssi_clk_o; next_pend = pend;       next_width = width;
    next_taint = taint;   next_busy = busy;       next_rderr = rderr;
    next_parerr = parerr; next_valid = valid;     next_result = result;
    next_irq = 1'b0;      finish = 1'b0;          sample = 1'b0;
    sbit = 1'b0;          bad = 1'b0;
    if (stat_wr) begin
      next_rderr  = rderr & ~wb_dat_i[ST_RDERR];
      next_parerr = parerr & ~wb_dat_i[ST_PARERR];
    end
    if (data_rd) begin
      next_valid = 1'b0;
    end
    case (state)
      ST_ENTRY: begin
        next_pend = 1'b0;
        next_clk  = LINE_IDLE; // RULE1
        next_busy = 1'b0;
        if (!ssi_mode) begin
          next_state = ST_OFF;
        end else if (listen) begin
          next_state = ST_L_ARMED; // RULE12
          next_busy  = 1'b1; // RULE14
          next_taint = ~lk; // RULE19
        end else begin
          // a burst cut by this write may leave the encoder mid-word
          next_timer = rec_cyc - TIMER_W'(1);
          next_state = ST_M_RECOVER; // RULE5 RULE6
        end
      end
      ST_M_IDLE: begin
        if (start || pend) begin // RULE16
          next_clk     = 1'b0; // RULE2
          next_timer   = half_cyc;
          next_bitcnt  = '0;
          next_shift   = '0;
          next_par_acc = 1'b0;
          next_par_bit = 1'b0;
          next_busy    = 1'b1;
          next_pend    = 1'b0;
          next_state   = ST_M_LOW;
        end
      end
      ST_M_LOW: begin
        if (timer == '0) begin
          next_clk   = 1'b1; // RULE3
          next_timer = half_cyc;
          next_state = ST_M_HIGH;
        end else begin
          next_timer = timer - TIMER_W'(1);
        end
      end
      ST_M_HIGH: begin
        if (timer != '0) begin
          next_timer = timer - TIMER_W'(1);
        end else if (bitcnt == total) begin
          finish     = 1'b1;
          next_timer = rec_cyc - TIMER_W'(1);
          next_state = ST_M_RECOVER;
        end else begin
          next_clk   = 1'b0;
          sample     = 1'b1; // RULE22
          sbit       = dt;
          next_timer = half_cyc;
          next_state = ST_M_LOW;
        end
      end
      ST_M_RECOVER: begin
        // a request during recovery waits rather than being lost
        if (start) begin
          next_pend = 1'b1;
          next_busy = 1'b1;
        end
        if (timer == '0) begin
          next_state = ST_M_IDLE; // RULE5
        end else begin
          next_timer = timer - TIMER_W'(1);
        end
      end
      ST_L_ARMED: begin
        if (fall) begin
          next_timer   = '0;
          next_bitcnt  = '0;
          next_shift   = '0;
          next_par_acc = 1'b0;
          next_par_bit = 1'b0;
          next_state   = ST_L_FIRST;
        end
      end
      ST_L_FIRST: begin
        if (rise) begin
          next_width = timer[WIDTH_W-1:0]; // RULE13
          next_timer = TIMER_W'(timer[WIDTH_W-1:0]) << WD_SHIFT; // RULE17
          next_state = ST_L_BITS;
        end else if (timer == TIMER_SAT) begin
          bad = 1'b1;
        end else begin
          next_timer = timer + TIMER_W'(1);
        end
      end
      ST_L_BITS: begin
        if (fall) begin
          sample     = 1'b1;
          sbit       = dt;
          next_timer = reload; // RULE17
          if (bitcnt + CNT_W'(1) == total) begin
            finish     = 1'b1;
            next_state = ST_L_HOLD;
          end
        end else if (timer == '0) begin
          bad = 1'b1; // RULE17
        end else begin
          next_timer = timer - TIMER_W'(1);
        end
      end
      ST_L_HOLD: begin
        if (data_rd) begin
          next_busy  = 1'b1; // RULE15
          next_state = ST_L_ARMED;
        end
      end
      default: begin
      end
    endcase
    if (sample) begin
      next_bitcnt = bitcnt + CNT_W'(1);
      if (bitcnt < bc_eff) begin
        next_shift   = {shift[DATA_W-2:0], sbit};
        next_par_acc = par_acc ^ sbit;
      end else if (ctrl[CTRL_PAR] && bitcnt == total - CNT_W'(1)) begin
        next_par_bit = sbit;
      end
    end
    if (finish) begin
      next_busy   = 1'b0; // RULE9 RULE14
      next_valid  = 1'b1;
      next_result = ctrl[CTRL_GRAY] ? gray2bin(next_shift) : next_shift;
      next_irq    = ctrl[CTRL_IRQ_EN]; // RULE21
      if (ctrl[CTRL_PAR] && ((next_par_acc ^ next_par_bit) != ctrl[CTRL_SENSE])) begin
        next_parerr = 1'b1; // RULE23
      end
      if (taint) begin
        next_rderr = 1'b1; // RULE19
        next_taint = 1'b0;
      end
    end
    if (bad) begin
      next_rderr = 1'b1;
      next_taint = 1'b0;
      next_busy  = ~brk; // RULE18
      next_state = brk ? ST_L_STOP : ST_L_ARMED; // RULE18
    end
    if (ctrl_wr) begin
      next_state = ST_ENTRY;
      next_clk   = LINE_IDLE; // RULE1
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always_comb begin
    next_ctrl = ctrl;
    for (int b = 0; b < 4; b++) begin
      if (ctrl_wr && wb_sel_i[b]) begin
        next_ctrl[8*b+:8] = wb_dat_i[8*b+:8];
      end
    end
    next_ctrl  = next_ctrl & CTRL_MASK;
    next_ack   = take;
    next_rdata = '0;
    case (wb_adr_i)
      REG_CTRL: next_rdata = ctrl;
      REG_DATA: next_rdata = 32'(result);
      REG_STATUS: begin
        next_rdata[ST_BUSY]   = busy;
        next_rdata[ST_RDERR]  = rderr & listen; // RULE11
        next_rdata[ST_PARERR] = parerr;
        next_rdata[ST_VALID]  = valid;
      end
      default: next_rdata = '0;
    endcase
    if (!rd) begin
      next_rdata = wb_dat_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_ENTRY;   ctrl <= CTRL_RESET;  timer <= '0;
      bitcnt <= '0;        shift <= '0;         result <= '0;
      width <= '0;         par_acc <= 1'b0;     par_bit <= 1'b0;
      pend <= 1'b0;        taint <= 1'b0;       busy <= 1'b0;
      rderr <= 1'b0;       parerr <= 1'b0;      valid <= 1'b0;
      ssi_clk_o <= LINE_IDLE;
      data_valid_irq_o <= 1'b0;
      wb_ack_o <= 1'b0;    wb_dat_o <= '0;      lk_d <= LINE_IDLE;
    end else begin
      state <= next_state; ctrl <= next_ctrl;   timer <= next_timer;
      bitcnt <= next_bitcnt; shift <= next_shift; result <= next_result;
      width <= next_width; par_acc <= next_par_acc; par_bit <= next_par_bit;
      pend <= next_pend;   taint <= next_taint; busy <= next_busy;
      rderr <= next_rderr; parerr <= next_parerr; valid <= next_valid;
      ssi_clk_o <= next_clk;
      data_valid_irq_o <= next_irq;
      wb_ack_o <= next_ack; wb_dat_o <= next_rdata; lk_d <= lk;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [TIMER_W-1:0] since_fin;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      since_fin <= HELPER_SAT;
    end else if (state == ST_M_HIGH && next_state == ST_M_RECOVER) begin
      since_fin <= '0;
    end else if (since_fin != HELPER_SAT) begin
      since_fin <= since_fin + TIMER_W'(1);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_launch;
    state == ST_M_LOW && !ssi_clk_o && busy;
  endsequence
  sequence s_relaunch;
    state == ST_M_IDLE ##1 state == ST_M_LOW;
  endsequence

  AST_CLK_IDLE_HIGH: assert property (ssi_clk_o == (state != ST_M_LOW)) // RULE1
    else $error("serial clock not high outside a low phase");
  AST_RECOVERY_WAIT: assert property (s_relaunch |-> $past(since_fin) >= rec_cyc) // RULE5
    else $error("burst started inside recovery time");
  AST_WRITE_STARTS: assert property ( // RULE9
    (state == ST_M_IDLE && data_wr && !ctrl_wr) |=> s_launch)
    else $error("data write did not start a burst");
  AST_TRIGGER_STARTS: assert property ( // RULE10
    (state == ST_M_IDLE && mcr_trigger_i && ctrl[CTRL_MCR_EN] && !ctrl_wr) |=> s_launch)
    else $error("trigger did not start a burst");
  AST_MASTER_NO_RDERR: assert property ( // RULE11
    (rd && wb_adr_i == REG_STATUS && !listen) |=> wb_ack_o && !wb_dat_o[ST_RDERR])
    else $error("read error visible in master mode");
  AST_LISTEN_IGNORES_WRITE: assert property ( // RULE16
    (listen && data_wr && state != ST_M_LOW) |=> ssi_clk_o [*2])
    else $error("data write disturbed listen mode");
  AST_LISTEN_BUSY: assert property ((state == ST_L_ARMED) |-> busy) // RULE14
    else $error("listener waiting without busy");
  AST_READ_REARM: assert property ( // RULE15
    (state == ST_L_HOLD && data_rd && !ctrl_wr) |=> state == ST_L_ARMED && busy)
    else $error("data read did not re-arm listener");
  AST_WATCHDOG: assert property ( // RULE17
    (state == ST_L_BITS && timer == '0 && !fall && !ctrl_wr) |=> rderr)
    else $error("watchdog expiry without read error");
  AST_OFF_MODE: assert property ((!ssi_mode && !ctrl_wr && !rst_i) [*2] |-> state == ST_OFF) // RULE20
    else $error("channel active outside serial mode");
  AST_IRQ_AT_END: assert property (data_valid_irq_o |-> !busy && valid) // RULE21
    else $error("interrupt without completed word");

endmodule

/* rtl/ssi_pkg.sv */
package ssi_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 4;
  localparam int NS_PER_US       = 1000;
  localparam int CYC_PER_US      = NS_PER_US / CLK_PERIOD_NS;
  localparam int HALF_US_CYC     = CYC_PER_US / 2;
  localparam int RECOVERY_MAX_US = 30;
  localparam int RECOVERY_CYC    = RECOVERY_MAX_US * CYC_PER_US;
  localparam int WD_SHIFT        = 2;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADR_W   = 4;
  localparam int TIMER_W = 16;
  localparam int WIDTH_W = 14;
  localparam int CNT_W   = 6;

  localparam logic [TIMER_W-1:0] TIMER_SAT = 16'h3FFF;
  localparam logic [TIMER_W-1:0] HELPER_SAT = 16'hFFFF;
  localparam logic               LINE_IDLE = 1'b1;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADR_W-1:0] REG_CTRL   = 4'h0;
  localparam logic [ADR_W-1:0] REG_DATA   = 4'h4;
  localparam logic [ADR_W-1:0] REG_STATUS = 4'h8;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK  = 32'h000F_FFFF;

  localparam int CTRL_BC_LSB    = 0;
  localparam int CTRL_GRAY      = 6;
  localparam int CTRL_ZB        = 7;
  localparam int CTRL_SENSE     = 8;
  localparam int CTRL_PAR       = 9;
  localparam int CTRL_CR_LSB    = 10;
  localparam int CTRL_CR_W      = 4;
  localparam int CTRL_LISTEN    = 14;
  localparam int CTRL_BREAK     = 15;
  localparam int CTRL_IFSEL_LSB = 16;
  localparam int CTRL_MCR_EN    = 18;
  localparam int CTRL_IRQ_EN    = 19;

  localparam int ST_BUSY   = 0;
  localparam int ST_RDERR  = 1;
  localparam int ST_PARERR = 2;
  localparam int ST_VALID  = 3;

  localparam logic [1:0] IFSEL_SSI = 2'h1;

  typedef enum logic [3:0] {
    ST_ENTRY, ST_OFF, ST_M_IDLE, ST_M_LOW, ST_M_HIGH, ST_M_RECOVER,
    ST_L_ARMED, ST_L_FIRST, ST_L_BITS, ST_L_HOLD, ST_L_STOP
  } chan_state_t;

endpackage

/* rtl/ssi_sync.sv */
`timescale 1ns/1ps
module ssi_sync #(
  parameter logic IDLE = 1'b1
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic din_i,
  output logic      dout_o
);
  logic s1;
  logic s2;
  logic s3;
  logic next_out;

  // a change counts only once the last two stages agree
  always_comb begin
    next_out = (s2 == s3) ? s2 : dout_o;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1     <= IDLE;
      s2     <= IDLE;
      s3     <= IDLE;
      dout_o <= IDLE;
    end else begin
      s1     <= din_i;
      s2     <= s1;
      s3     <= s2;
      dout_o <= next_out;
    end
  end
endmodule

/* sim/ssi_encoder_model.sv */
`timescale 1ns/1ps
// --------------------
// absolute encoder
// --------------------
module ssi_encoder_model #(
  parameter int RECOVER_NS = 600
) (
  input  wire logic        clk_line_i,
  input  wire logic [33:0] frame_i,
  input  wire logic [5:0]  total_i,
  output logic             data_o
);
  logic [33:0] word;
  int          sent;
  logic        active = 1'b0;

  initial data_o = 1'b1;

  always @(negedge clk_line_i) begin
    if (!active) begin
      word   = frame_i;
      sent   = 0;
      active = 1'b1;
    end
  end

  // shorter than the controller wait, so only an early start would corrupt the word
  always @(posedge clk_line_i) begin
    if (active && sent < int'(total_i)) begin
      data_o <= word[int'(total_i) - 1 - sent];
      sent   += 1;
    end else if (active) begin
      data_o <= 1'b0;
      active  = 1'b0;
      #(RECOVER_NS) data_o <= 1'b1;
    end
  end
endmodule

/* sim/ssi_encoder_channel_tb_top.sv */
`timescale 1ns/1ps
module ssi_encoder_channel_tb_top;
  import ssi_pkg::*;
  localparam int          REC  = 200;
  localparam logic [31:0] FULL = 32'hFFFF_FFFF;
  localparam logic [31:0] BASE = (32'h1 << CTRL_IRQ_EN) | (32'h1 << CTRL_CR_LSB);
  localparam logic [31:0] SSI  = 32'h1 << CTRL_IFSEL_LSB;
  localparam logic [31:0] LSN  = 32'h1 << CTRL_LISTEN;
  logic        clk_i         = 1'b0;
  logic        rst_i         = 1'b1;
  logic        wb_cyc_i      = 1'b0;
  logic        wb_stb_i      = 1'b0;
  logic        wb_we_i       = 1'b0;
  logic [3:0]  wb_adr_i      = 4'h0;
  logic [3:0]  wb_sel_i      = 4'hF;
  logic [31:0] wb_dat_i      = 32'h0;
  logic        mcr_trigger_i = 1'b0;
  logic        link_clk      = 1'b1;
  logic        listen        = 1'b0;
  logic [33:0] frame         = 34'h0;
  logic [5:0]  total         = 6'h0;
  logic        clk_q         = 1'b1;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        ssi_clk_o;
  logic        ssi_data_i;
  logic        data_valid_irq_o;
  logic [31:0] rd;
  int          errors = 0;
  int          comparisons = 0;
  int          irqs = 0;
  int          falls = 0;
  int          since = 100000;
  int          cycles = 0;

  always #2 clk_i = ~clk_i;

  ssi_encoder_channel #(.RECOVERY_CYC(REC)) i_ssi_encoder_channel (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mcr_trigger_i(mcr_trigger_i),
    .ssi_clk_o(ssi_clk_o), .ssi_clk_in_i(link_clk), .ssi_data_i(ssi_data_i),
    .data_valid_irq_o(data_valid_irq_o));

  ssi_encoder_model i_ssi_encoder_model (
    .clk_line_i(listen ? link_clk : ssi_clk_o), .frame_i(frame),
    .total_i(total), .data_o(ssi_data_i));

  // --------------------
  // checking and report
  // --------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons += 1;
    if (seen !== exp) begin
      errors += 1;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // completion pulses, serial clock falling edges and the hang limit
  always @(posedge clk_i) begin
    cycles += 1;
    since  += 1;
    clk_q  <= ssi_clk_o;
    if (data_valid_irq_o === 1'b1) begin
      irqs += 1;
      since = 0;
    end
    if (clk_q === 1'b1 && ssi_clk_o === 1'b0) begin
      falls += 1;
      check(32'(since >= REC), 32'h1);
    end
    if (cycles > 60000) begin
      errors += 1;
      results();
    end
  end

  // --------------------
  // access tasks
  // --------------------
  task automatic bus(input logic we, input logic [3:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] adr, input logic [31:0] dat);
    bus(1'b1, adr, dat);
  endtask

  task automatic rdx(input logic [3:0] adr, input logic [31:0] m, input logic [31:0] exp);
    bus(1'b0, adr, 32'h0);
    check(rd & m, exp);
  endtask

  task automatic wait_done();
    do bus(1'b0, REG_STATUS, 32'h0); while (rd[ST_BUSY] === 1'b1);
  endtask

  // f: gray, zero bit, parity, odd, corrupt parity
  task automatic cfg(input logic [31:0] pos, input int n, input logic [4:0] f);
    logic [31:0] w;
    w = (f[4] ? pos ^ (pos >> 1) : pos) & ((32'h1 << n) - 32'h1);
    frame = {2'h0, w};
    if (f[3]) frame = frame << 1;
    if (f[2]) frame = {frame[32:0], ^w ^ f[1] ^ f[0]};
    total = 6'(n + int'(f[3]) + int'(f[2]));
  endtask

  // a start request that must not produce any clock burst
  task automatic poke();
    int f0;
    f0 = falls;
    wr(REG_DATA, 32'h0);
    @(posedge clk_i);
    mcr_trigger_i <= 1'b1;
    @(posedge clk_i);
    mcr_trigger_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    check(32'(falls - f0), 32'h0);
  endtask

  // link clock off the system clock phase, still between frames
  task automatic burst(input int k);
    @(posedge clk_i);
    #1.3;
    repeat (k) begin
      link_clk = 1'b0;
      #32;
      link_clk = 1'b1;
      #32;
    end
  endtask

  // --------------------
  // tests
  // --------------------
  initial begin
    int n;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    check(32'(ssi_clk_o), 32'h1);
    rdx(REG_CTRL, FULL, CTRL_RESET);
    rdx(4'hC, FULL, 32'h0);
    cfg(32'h0000_0ABC, 12, 5'h00);
    wr(REG_CTRL, BASE | SSI | 32'h0000_000C);
    wr(REG_DATA, 32'h0);
    wait_done();
    wr(REG_DATA, 32'h0);
    rdx(REG_STATUS, 32'h0000_000E, 32'h0000_0008);
    rdx(REG_DATA, FULL, 32'h0000_0ABC);
    repeat (REC + 10) @(posedge clk_i);
    wait_done();
    rdx(REG_DATA, FULL, 32'h0000_0ABC);
    repeat (REC + 10) @(posedge clk_i);
    wr(REG_DATA, 32'h0);
    wait_done();
    rdx(REG_DATA, FULL, 32'h0000_0ABC);
    check(32'(irqs), 32'h3);
    for (int b = 0; b < 2; b++) begin
      cfg(32'h0005_A5A5, 20, {4'hF, b[0]});
      wr(REG_CTRL, BASE | SSI | 32'h0000_03D4);
      wr(REG_DATA, 32'h0);
      wait_done();
      rdx(REG_STATUS, 32'h0000_0004, {29'h0, b[0], 2'h0});
      rdx(REG_DATA, FULL, 32'h0005_A5A5);
    end
    cfg(32'h0000_005A, 8, 5'h00);
    wr(REG_CTRL, BASE | SSI | (32'h1 << CTRL_MCR_EN) | 32'h0000_0008);
    repeat (REC + 10) @(posedge clk_i);
    @(posedge clk_i);
    mcr_trigger_i <= 1'b1;
    @(posedge clk_i);
    mcr_trigger_i <= 1'b0;
    wait_done();
    rdx(REG_DATA, FULL, 32'h0000_005A);
    for (int c = 0; c < 4; c++) begin
      if (c != 1) begin
        wr(REG_CTRL, BASE | (32'h1 << CTRL_MCR_EN) | (32'(c) << CTRL_IFSEL_LSB));
        poke();
      end
    end
    listen <= 1'b1;
    cfg(32'h0000_0C3A, 12, 5'h00);
    wr(REG_CTRL, BASE | SSI | LSN | (32'hF << CTRL_CR_LSB) | 32'h0000_000C);
    poke();
    rdx(REG_STATUS, 32'h0000_0001, 32'h0000_0001);
    burst(13);
    repeat (200) @(posedge clk_i);
    rdx(REG_STATUS, 32'h0000_000B, 32'h0000_0008);
    rdx(REG_DATA, FULL, 32'h0000_0C3A);
    rdx(REG_STATUS, 32'h0000_0001, 32'h0000_0001);
    cfg(32'h0000_00FF, 8, 5'h00);
    burst(9);
    repeat (200) @(posedge clk_i);
    rdx(REG_STATUS, 32'h0000_0003, 32'h0000_0003);
    wr(REG_STATUS, 32'h0000_0002);
    wr(REG_CTRL, BASE | SSI | LSN | (32'h1 << CTRL_BREAK) | 32'h0000_000C);
    burst(9);
    repeat (200) @(posedge clk_i);
    rdx(REG_STATUS, 32'h0000_0002, 32'h0000_0002);
    n = irqs;
    cfg(32'h0000_0C3A, 12, 5'h00);
    burst(13);
    repeat (200) @(posedge clk_i);
    check(32'(irqs), 32'(n));
    // listener switched on while the observed clock is already low
    wr(REG_STATUS, 32'h0000_0002);
    #1.3 link_clk = 1'b0;
    repeat (8) @(posedge clk_i);
    wr(REG_CTRL, BASE | SSI | LSN | 32'h0000_000C);
    burst(14);
    repeat (200) @(posedge clk_i);
    rdx(REG_STATUS, 32'h0000_000B, 32'h0000_000A);
    results();
  end
endmodule
